// ===== pkg/mem_status_cfg.svh
/*
  Constants for the memory status and translation slice: register byte
  offsets, status bit positions, fault codes and widths.
  Assumes it is included by bare name after the package is compiled.
*/
`ifndef MEM_STATUS_CFG_SVH
`define MEM_STATUS_CFG_SVH

// Register byte offsets on the AHB-Lite slave.
`define OFF_CONDITION 8'h00
`define OFF_DATA 8'h04
`define OFF_CONTROL 8'h08
`define OFF_SEG_COUNT 8'h0c
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14
`define OFF_ENTRY_INDEX 8'h18
`define OFF_ENTRY_DATA 8'h1c

// Condition register bit positions.
`define BIT_NVM 15
`define BIT_FAULT_HI 14
`define BIT_FAULT_LO 13
`define BIT_DMA_BYTE 7
`define BIT_DMA_ERR 6

// Fault type codes.
`define FLT_EXECUTE 2'h0
`define FLT_WRITE 2'h1
`define FLT_READ 2'h2
`define FLT_LEVEL 2'h3

// Interrupt status bit positions.
`define IRQ_FAULT 0
`define IRQ_DMA_ERR 1
`define IRQ_MALFUNC 2
`define IRQ_WIDTH 3

// Table entry layout: bias, present, read, write, execute, level.
`define ENT_BIAS_HI 21
`define ENT_PRESENT 24
`define ENT_READ 25
`define ENT_WRITE 26
`define ENT_EXEC 27
`define ENT_LEVEL_LO 28
`define ENT_LEVEL_HI 29
`define ENT_WIDTH 30

// Address widths and the segment field.
`define VA_WIDTH 24
`define RA_WIDTH 22
`define SEG_HI 15
`define SEG_LO 8
`define NIBBLE_HI 3
`define HTRANS_NONSEQ_BIT 1

`endif

// ===== pkg/mem_status_pkg.sv
/*
  Types shared by the memory status and translation slice.
  Assumes nothing of its surroundings.
*/
package mem_status_pkg;

  // Kind of memory access presented to the translator.
  typedef enum logic [1:0] {ACC_EXECUTE, ACC_WRITE, ACC_READ} access_e;

  typedef logic [15:0] half_t;

endpackage

// ===== verilog/memory_status_translation.sv
/*
  Memory unit status and address-translation slice: condition register,
  memory data register, segment-table translator, DMA double-bit error
  handling, interrupt status and an AHB-Lite register slave.
  Assumes one clock, inputs synchronous to it, and a single AHB master.
*/
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "mem_status_cfg.svh"
module memory_status_translation
  import mem_status_pkg::*;
#(
  parameter int SEG_ENTRIES = 256
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Status sources.
  input wire logic nonvalid_memory_flag,
  input wire logic dma_byte_indicator,
  input wire logic double_bit_error,
  input wire logic dma_irq_service,
  input wire logic dma_transfer_active,
  input wire logic interruptible_fetch,
  // Data register load sources and internal bus.
  input wire logic array_load,
  input wire logic [15:0] array_data,
  input wire logic eu_load,
  input wire logic [15:0] eu_data,
  input wire logic translator_load,
  input wire logic condition_select,
  input wire logic data_select,
  input wire logic nibble_read,
  output logic [15:0] internal_bus,
  output logic [3:0] short_operand,
  // Translator.
  input wire logic access_valid,
  input wire logic [1:0] access_kind,
  input wire logic [1:0] psw_level,
  input wire logic [23:0] virtual_address,
  output logic translate_done,
  output logic [21:0] real_address,
  output logic translation_fault,
  output logic fault_type_high,
  output logic fault_type_low,
  // DMA control and interrupt.
  output logic dma_halt,
  output logic dma_terminate,
  output logic machine_malfunction,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  // A word write lands on a register when the latched address matches.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  // Sum of virtual address bits 15:0 and the entry bias, cut to physical width.
  function automatic logic [21:0] relocate(input logic [23:0] va, input logic [21:0] bias);
    relocate = bias + {6'h00, va[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state; each next_ value is the input of its own flop.
  logic ph_write, ph_read, next_ph_write, next_ph_read;
  logic [7:0] ph_addr, next_ph_addr;
  logic translate_enable, next_translate_enable;
  logic [7:0] seg_count, next_seg_count, entry_index, next_entry_index;
  logic [`IRQ_WIDTH-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
  logic [`ENT_WIDTH-1:0] seg_table [SEG_ENTRIES];
  half_t memory_data_reg, next_memory_data_reg, memory_condition_reg;
  logic [15:0] next_internal_bus;
  logic dma_error_status, next_dma_error_status, next_dma_halt, next_dma_terminate, next_malfunction;
  logic [1:0] fault_code, next_fault_code;
  logic [21:0] next_real_address;
  logic next_done, next_fault;
  logic fault_event, dma_err_event, malfunction_event, status_read, table_write;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture.
  // The slave never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Only word transfers are expected; hsize is accepted as given.
  always_comb
  begin
    next_ph_write = 1'b0;
    next_ph_read = 1'b0;
    next_ph_addr = ph_addr;
    if (hready && hsel && htrans[`HTRANS_NONSEQ_BIT])
    begin
      next_ph_write = hwrite;
      next_ph_read = !hwrite;
      next_ph_addr = haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ph_write <= 1'b0;
      ph_read <= 1'b0;
      ph_addr <= 8'h00;
    end
    else
    begin
      ph_write <= next_ph_write;
      ph_read <= next_ph_read;
      ph_addr <= next_ph_addr;
    end
  end

  // Read data is a mux of flops and live status in the data phase, so a read right after a
  // write to the same register already sees the written value.
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (ph_read)
    begin
      unique case (ph_addr)
        `OFF_CONDITION: hrdata = {16'h0000, memory_condition_reg};
        `OFF_DATA: hrdata = {16'h0000, memory_data_reg};
        `OFF_CONTROL: hrdata = {31'h0000_0000, translate_enable};
        `OFF_SEG_COUNT: hrdata = {24'h00_0000, seg_count};
        `OFF_IRQ_STATUS: hrdata = {29'h0000_0000, irq_status};
        `OFF_IRQ_MASK: hrdata = {29'h0000_0000, irq_mask};
        `OFF_ENTRY_INDEX: hrdata = {24'h00_0000, entry_index};
        `OFF_ENTRY_DATA: hrdata = {2'h0, seg_table[entry_index]};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign status_read = ph_read && hit(ph_addr, `OFF_IRQ_STATUS);
  assign table_write = ph_write && hit(ph_addr, `OFF_ENTRY_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Software control registers and interrupt status.
  // Status bits are sticky; an event in the clearing read cycle survives.
  always_comb
  begin
    next_translate_enable = translate_enable;
    next_seg_count = seg_count;
    next_entry_index = entry_index;
    next_irq_mask = irq_mask;
    next_irq_status = status_read ? '0 : irq_status;
    if (ph_write && hit(ph_addr, `OFF_CONTROL))
      next_translate_enable = hwdata[0];
    if (ph_write && hit(ph_addr, `OFF_SEG_COUNT))
      next_seg_count = hwdata[7:0];
    if (ph_write && hit(ph_addr, `OFF_ENTRY_INDEX))
      next_entry_index = hwdata[7:0];
    if (ph_write && hit(ph_addr, `OFF_IRQ_MASK))
      next_irq_mask = hwdata[`IRQ_WIDTH-1:0];
    if (fault_event)
      next_irq_status[`IRQ_FAULT] = 1'b1;
    if (dma_err_event)
      next_irq_status[`IRQ_DMA_ERR] = 1'b1;
    if (malfunction_event)
      next_irq_status[`IRQ_MALFUNC] = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      translate_enable <= 1'b0;
      seg_count <= 8'h00;
      entry_index <= 8'h00;
      irq_status <= '0;
      irq_mask <= '0;
    end
    else
    begin
      translate_enable <= next_translate_enable;
      seg_count <= next_seg_count;
      entry_index <= next_entry_index;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // The segment table is plain storage and needs no reset; software fills it.
  always_ff @(posedge clk_sys)
  begin
    if (table_write)
      seg_table[entry_index] <= hwdata[`ENT_WIDTH-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Translator: one registered result per access request.
  // Level is checked after the access mode, so it wins the fault code.
  always_comb
  begin
    logic [`ENT_WIDTH-1:0] ent;
    logic [7:0] seg;
    logic bad;
    logic [1:0] code;
    ent = '0;
    seg = virtual_address[`SEG_HI:`SEG_LO];
    bad = 1'b0;
    code = fault_code;
    next_done = access_valid;
    next_fault = 1'b0;
    next_fault_code = fault_code;
    next_real_address = real_address;
    if (access_valid)
    begin
      if (!translate_enable)
      begin
        next_real_address = virtual_address[`RA_WIDTH-1:0];
      end
      else
      begin
        ent = seg_table[seg];
        next_real_address = relocate(virtual_address, ent[`ENT_BIAS_HI:0]);
        unique case (access_kind)
          ACC_EXECUTE: bad = !ent[`ENT_EXEC];
          ACC_WRITE: bad = !ent[`ENT_WRITE];
          default: bad = !ent[`ENT_READ];
        endcase
        unique case (access_kind)
          ACC_EXECUTE: code = `FLT_EXECUTE;
          ACC_WRITE: code = `FLT_WRITE;
          default: code = `FLT_READ;
        endcase
        if (psw_level < ent[`ENT_LEVEL_HI:`ENT_LEVEL_LO])
        begin
          bad = 1'b1;
          code = `FLT_LEVEL;
        end
        if (!ent[`ENT_PRESENT] || seg > seg_count)
          bad = 1'b1;
        next_fault = bad;
        if (bad)
          next_fault_code = code;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      translate_done <= 1'b0;
      translation_fault <= 1'b0;
      fault_code <= `FLT_EXECUTE;
      real_address <= 22'h00_0000;
    end
    else
    begin
      translate_done <= next_done;
      translation_fault <= next_fault;
      fault_code <= next_fault_code;
      real_address <= next_real_address;
    end
  end

  assign fault_type_high = fault_code[1];
  assign fault_type_low = fault_code[0];
  assign fault_event = translation_fault;

  ////////////////////////////////////////////////////////////////////////////
  // DMA double-bit error handling.
  // A double-bit error during DMA never reaches the malfunction path.
  assign dma_err_event = double_bit_error && dma_transfer_active;
  assign malfunction_event = double_bit_error && !dma_transfer_active;

  always_comb
  begin
    next_dma_error_status = dma_error_status;
    next_dma_halt = dma_halt;
    next_dma_terminate = 1'b0;
    next_malfunction = malfunction_event;
    if (dma_halt && interruptible_fetch)
    begin
      next_dma_halt = 1'b0;
      next_dma_terminate = 1'b1;
      next_dma_error_status = 1'b0;
    end
    if (double_bit_error && dma_irq_service)
      next_dma_error_status = 1'b1;
    if (dma_err_event)
      next_dma_halt = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dma_error_status <= 1'b0;
      dma_halt <= 1'b0;
      dma_terminate <= 1'b0;
      machine_malfunction <= 1'b0;
    end
    else
    begin
      dma_error_status <= next_dma_error_status;
      dma_halt <= next_dma_halt;
      dma_terminate <= next_dma_terminate;
      machine_malfunction <= next_malfunction;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition register, data register and internal bus.
  // Read-only view assembled from live sources; unused bits read as zero.
  always_comb
  begin
    memory_condition_reg = 16'h0000;
    memory_condition_reg[`BIT_NVM] = nonvalid_memory_flag;
    memory_condition_reg[`BIT_FAULT_HI] = fault_type_high;
    memory_condition_reg[`BIT_FAULT_LO] = fault_type_low;
    memory_condition_reg[`BIT_DMA_BYTE] = dma_byte_indicator;
    memory_condition_reg[`BIT_DMA_ERR] = dma_error_status;
  end

  // Array read has priority, then execution unit, translator, then software.
  always_comb
  begin
    next_memory_data_reg = memory_data_reg;
    if (array_load)
      next_memory_data_reg = array_data;
    else if (eu_load)
      next_memory_data_reg = eu_data;
    else if (translator_load)
      next_memory_data_reg = next_real_address[15:0];
    else if (ph_write && hit(ph_addr, `OFF_DATA))
      next_memory_data_reg = hwdata[15:0];
  end

  // Condition source wins when both are selected; no source gives zero.
  always_comb
  begin
    next_internal_bus = 16'h0000;
    if (condition_select)
      next_internal_bus = memory_condition_reg;
    else if (data_select && nibble_read)
      next_internal_bus = {12'h000, memory_data_reg[`NIBBLE_HI:0]};
    else if (data_select)
      next_internal_bus = memory_data_reg;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      memory_data_reg <= 16'h0000;
      internal_bus <= 16'h0000;
    end
    else
    begin
      memory_data_reg <= next_memory_data_reg;
      internal_bus <= next_internal_bus;
    end
  end

  assign short_operand = memory_data_reg[`NIBBLE_HI:0];
endmodule
`default_nettype wire

// ===== test/mem_status_properties.sv
/* Port assertions for the memory status slice.
   Assumes a bind to the top module and a single clock. */
`timescale 1ns/1ns
`default_nettype none
module mem_status_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic nonvalid_memory_flag,
  input wire logic dma_byte_indicator,
  input wire logic double_bit_error,
  input wire logic dma_transfer_active,
  input wire logic condition_select,
  input wire logic data_select,
  input wire logic nibble_read,
  input wire logic [15:0] internal_bus,
  input wire logic access_valid,
  input wire logic translate_done,
  input wire logic translation_fault,
  input wire logic dma_halt,
  input wire logic dma_terminate,
  input wire logic machine_malfunction
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // The translator answers exactly one cycle after each request.
  done_on_time_a:
    assert property (access_valid |=> translate_done) else $error("done late");
  done_only_a:
    assert property (!access_valid |=> !translate_done) else $error("stray done");
  fault_with_done_a:
    assert property (translation_fault |-> translate_done) else $error("lone fault");
  // Condition select shows the live flags a cycle later.
  cond_on_bus_a:
    assert property (condition_select |=> internal_bus[15] == $past(nonvalid_memory_flag)
      && internal_bus[7] == $past(dma_byte_indicator)) else $error("cond bits");
  nibble_zero_a:
    assert property (!condition_select && data_select && nibble_read |=> internal_bus[15:4] == 12'h0)
      else $error("nibble high");
  // A DMA double-bit error halts quietly; elsewhere it is a malfunction.
  halt_on_error_a:
    assert property (double_bit_error && dma_transfer_active |=> dma_halt && !machine_malfunction)
      else $error("no halt");
  malfunction_a:
    assert property (double_bit_error && !dma_transfer_active |=> machine_malfunction) else $error("no malf");
  end_after_halt_a:
    assert property (dma_terminate |-> $past(dma_halt)) else $error("bad end");
endmodule
`default_nettype wire

// ===== test/dma_seq_model.sv
/* Far-side DMA sequencer: the byte indicator of a selector transfer.
   Assumes the bench pulses step once per byte moved. */
`timescale 1ns/1ns
`default_nettype none
module dma_seq_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic active,
  input wire logic step,
  output logic byte_ind
);
  logic next_byte_ind;
  // An idle channel restarts on the first byte, so it never shows a stale second byte.
  always_comb
  begin
    next_byte_ind = byte_ind;
    if (!active)
      next_byte_ind = 1'b0;
    else if (step)
      next_byte_ind = !byte_ind;
  end
  // Register the indicator.
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      byte_ind <= 1'b0;
    else
      byte_ind <= next_byte_ind;
endmodule
`default_nettype wire

// ===== test/memory_status_translation_tb.sv
/* Self-checking bench for the memory status and translation slice.
   Assumes the design, its checker and the sequencer model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "mem_status_cfg.svh"
module memory_status_translation_tb import mem_status_pkg::*;;
  logic clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, hresp, rd_ph, step;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [31:0] ents[1:4];
  logic [1:0] htrans, access_kind, psw_level;
  logic nonvalid_memory_flag, dma_byte_indicator, double_bit_error, dma_irq_service, dma_transfer_active;
  logic interruptible_fetch, array_load, eu_load, condition_select, data_select, nibble_read, access_valid;
  logic translate_done, translation_fault, fault_type_high, fault_type_low, translator_load;
  logic dma_halt, dma_terminate, machine_malfunction, irq;
  half_t array_data, eu_data, internal_bus;
  logic [3:0] short_operand;
  logic [23:0] virtual_address;
  logic [21:0] real_address;
  logic [24:0] te;
  logic [31:0] rd_q[$];
  logic [24:0] tr_q[$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  assign hready = hreadyout;
  memory_status_translation uut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .nonvalid_memory_flag, .dma_byte_indicator, .double_bit_error,
    .dma_irq_service, .dma_transfer_active, .interruptible_fetch, .array_load, .array_data, .eu_load, .eu_data,
    .translator_load, .condition_select, .data_select, .nibble_read, .internal_bus, .short_operand,
    .access_valid, .access_kind, .psw_level, .virtual_address, .translate_done, .real_address,
    .translation_fault, .fault_type_high, .fault_type_low, .dma_halt, .dma_terminate, .machine_malfunction, .irq);
  dma_seq_model seq (.clk_sys, .sys_rst, .active(dma_transfer_active), .step, .byte_ind(dma_byte_indicator));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ent(input logic [21:0] b, input logic [3:0] xwrp, input logic [1:0] l);
    return {2'h0, l, xwrp, 2'h0, b};
  endfunction
  function automatic logic [31:0] cond(input logic [1:0] c, input logic e);
    return {16'h0, nonvalid_memory_flag, c, 5'h0, dma_byte_indicator, e, 6'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One single AHB-Lite transfer; the address phase holds until hready is seen.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic tr(input logic [1:0] k, input logic [1:0] l, input logic [23:0] v, input logic [24:0] e);
    tr_q.push_back(e);
    access_kind <= k;
    psw_level <= l;
    virtual_address <= v;
    access_valid <= 1'b1;
    @(posedge clk_sys);
    access_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Read data is compared at the edge that ends its data phase.
  always @(posedge clk_sys)
    if (rd_ph === 1'b1)
    begin
      check(hrdata, rd_q.pop_front());
      check(32'(hresp), 32'h0);
    end
  // Translation results: the code only counts on a fault, the address only without one.
  always @(posedge clk_sys)
    if (translate_done === 1'b1)
    begin
      te = tr_q.pop_front();
      check(32'(translation_fault), 32'(te[24]));
      if (te[24])
        check(32'({fault_type_high, fault_type_low}), 32'(te[23:22]));
      else
        check(32'(real_address), 32'(te[21:0]));
    end
  // A hang is cut short well past the expected hundred or so cycles.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      give_verdict();
    end
  end
  // Main sequence.
  initial
  begin
    {hsel, hwrite, rd_ph, step, double_bit_error, dma_irq_service, dma_transfer_active} = '0;
    {interruptible_fetch, array_load, eu_load, condition_select, data_select, nibble_read, access_valid} = '0;
    {haddr, hwdata, htrans, access_kind, psw_level, virtual_address, array_data, eu_data} = '0;
    translator_load = 1'b0;
    nonvalid_memory_flag = 1'b1;
    sys_rst = 1'b1;
    seed = 32'h023a85da;
    ents[1] = ent(22'h3f0000, 4'hf, 2'h1);
    ents[2] = ent(22'h3fff00, 4'h3, 2'h0);
    ents[3] = ent(22'h0, 4'he, 2'h0);
    ents[4] = ent(22'h0, 4'hf, 2'h0);
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    bus(`OFF_CONDITION, 1'b1, 32'hffff);
    rd(`OFF_CONDITION, cond(2'h0, 1'b0));
    rd(`OFF_CONTROL, 32'h0);
    rd(8'h20, 32'h0);
    seed = lfsr(seed);
    bus(`OFF_DATA, 1'b1, {16'h0, seed[15:0]});
    rd(`OFF_DATA, {16'h0, seed[15:0]});
    $display("registers test done");
    seed = lfsr(seed);
    array_data <= seed[15:0];
    eu_data <= seed[31:16];
    {array_load, eu_load} <= 2'h3;
    @(posedge clk_sys);
    {array_load, eu_load, data_select, nibble_read} <= 4'h3;
    @(posedge clk_sys);
    nibble_read <= 1'b0;
    @(negedge clk_sys);
    check(32'(internal_bus), 32'(array_data[3:0]));
    check(32'(short_operand), 32'(array_data[3:0]));
    @(posedge clk_sys);
    {eu_load, condition_select} <= 2'h3;
    @(negedge clk_sys);
    check(32'(internal_bus), 32'(array_data));
    @(posedge clk_sys);
    {eu_load, condition_select, data_select} <= 3'h0;
    @(negedge clk_sys);
    check(32'(internal_bus), cond(2'h0, 1'b0));
    check(32'(short_operand), 32'(eu_data[3:0]));
    @(posedge clk_sys);
    rd(`OFF_DATA, 32'(eu_data));
    $display("data register test done");
    seed = lfsr(seed);
    tr(2'h2, 2'h0, seed[23:0], {3'h0, seed[21:0]});
    // Four entries with a count of three; the table stays within 256 entries.
    bus(`OFF_SEG_COUNT, 1'b1, 32'h3);
    for (int i = 1; i < 5; i++)
    begin
      bus(`OFF_ENTRY_INDEX, 1'b1, 32'(i));
      bus(`OFF_ENTRY_DATA, 1'b1, ents[i]);
    end
    bus(`OFF_CONTROL, 1'b1, 32'h1);
    tr(2'h2, 2'h1, 24'h5a01c3, {3'h0, 22'h3f01c3});
    tr(2'h1, 2'h2, 24'h0001ff, {3'h0, 22'h3f01ff});
    tr(2'h2, 2'h0, 24'h0001c3, {3'h7, 22'h0});
    tr(2'h1, 2'h3, 24'h000200, {3'h5, 22'h0});
    tr(2'h0, 2'h3, 24'h000200, {3'h4, 22'h0});
    tr(2'h2, 2'h3, 24'h000210, {3'h0, 22'h000110});
    // The held translated address is loaded into the data register.
    translator_load <= 1'b1;
    @(posedge clk_sys);
    translator_load <= 1'b0;
    rd(`OFF_DATA, 32'h0000_0110);
    tr(2'h3, 2'h0, 24'h000200, {3'h0, 22'h000100});
    tr(2'h2, 2'h3, 24'h000300, {3'h6, 22'h0});
    tr(2'h1, 2'h0, 24'h000400, {3'h5, 22'h0});
    rd(`OFF_CONDITION, cond(2'h1, 1'b0));
    $display("translation test done");
    bus(`OFF_IRQ_MASK, 1'b1, 32'h3);
    rd(`OFF_IRQ_MASK, 32'h3);
    rd(`OFF_IRQ_STATUS, 32'h1);
    rd(`OFF_IRQ_STATUS, 32'h0);
    {dma_transfer_active, dma_irq_service, step} <= 3'h7;
    nonvalid_memory_flag <= 1'b0;
    @(posedge clk_sys);
    {double_bit_error, step} <= 2'h2;
    @(posedge clk_sys);
    double_bit_error <= 1'b0;
    @(negedge clk_sys);
    check(32'({dma_halt, machine_malfunction}), 32'h2);
    @(posedge clk_sys);
    rd(`OFF_CONDITION, cond(2'h1, 1'b1));
    interruptible_fetch <= 1'b1;
    @(posedge clk_sys);
    interruptible_fetch <= 1'b0;
    @(negedge clk_sys);
    check(32'({dma_halt, dma_terminate, irq}), 32'h3);
    @(posedge clk_sys);
    {dma_transfer_active, dma_irq_service} <= 2'h0;
    repeat (2) @(posedge clk_sys);
    rd(`OFF_CONDITION, cond(2'h1, 1'b0));
    rd(`OFF_IRQ_STATUS, 32'h2);
    double_bit_error <= 1'b1;
    @(posedge clk_sys);
    double_bit_error <= 1'b0;
    @(negedge clk_sys);
    check(32'({machine_malfunction, irq}), 32'h2);
    @(posedge clk_sys);
    rd(`OFF_IRQ_STATUS, 32'h4);
    $display("dma and interrupt test done");
    give_verdict();
  end
endmodule
bind memory_status_translation mem_status_properties chk (.clk_sys, .sys_rst, .nonvalid_memory_flag,
  .dma_byte_indicator, .double_bit_error, .dma_transfer_active, .condition_select, .data_select,
  .nibble_read, .internal_bus, .access_valid, .translate_done, .translation_fault, .dma_halt,
  .dma_terminate, .machine_malfunction);
`default_nettype wire
